/* rtl/mpad_attr_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module mpad_attr_decode (
  // Attribute byte in.
  input wire logic [7:0] attr_byte,
  // Decoded fields out.
  output logic is_device,
  output logic [1:0] device_order,
  output mpad_pkg::mpad_mem_t outer_type,
  output mpad_pkg::mpad_mem_t inner_type,
  output logic outer_transient,
  output logic inner_transient,
  output logic [1:0] outer_alloc,
  output logic [1:0] inner_alloc,
  output logic attr_unpredictable
);
  logic [3:0] outer_nib;
  logic [3:0] inner_nib;

  // Map one nibble to its normal-memory class; shared by both halves.
  function automatic mpad_pkg::mpad_mem_t nib_type(input logic [3:0] n);
    if (n == mpad_pkg::NIB_NONCACHE) return mpad_pkg::MPAD_NORMAL_NC;
    else if (n[3:2] == mpad_pkg::POL_WB_TRANS || n[3:2] == mpad_pkg::POL_WB_NONTRANS)
      return mpad_pkg::MPAD_NORMAL_WB;
    else return mpad_pkg::MPAD_NORMAL_WT;
  endfunction

  // Nibble split and decode.
  assign outer_nib = attr_byte[7:4];
  assign inner_nib = attr_byte[3:0];
  assign is_device = (outer_nib == mpad_pkg::NIB_DEVICE); // R01
  assign device_order = attr_byte[3:2]; // R18
  assign outer_type = is_device ? mpad_pkg::MPAD_DEVICE : nib_type(outer_nib); // R02 R03
  assign inner_type = is_device ? mpad_pkg::MPAD_DEVICE : nib_type(inner_nib); // R05 R06 R07
  assign outer_transient = !is_device && !outer_nib[3] && (outer_nib != mpad_pkg::NIB_NONCACHE); // R03
  assign inner_transient = !is_device && !inner_nib[3] && (inner_nib != mpad_pkg::NIB_NONCACHE); // R07
  // R bit is bit 1, W bit is bit 0; non-cacheable or device allocate nothing.
  assign outer_alloc = (outer_type == mpad_pkg::MPAD_NORMAL_NC || is_device) ? 2'h0 : outer_nib[1:0]; // R08
  assign inner_alloc = (inner_type == mpad_pkg::MPAD_NORMAL_NC || is_device) ? 2'h0 : inner_nib[1:0]; // R08
  // Inner zero under normal outer, or transient with both hints clear, is flagged.
  assign attr_unpredictable = (!is_device && inner_nib == 4'h0) // R05
    || (outer_transient && outer_nib[1:0] == 2'h0) || (inner_transient && inner_nib[1:0] == 2'h0); // R04
endmodule // mpad_attr_decode
`default_nettype wire

/* rtl/mpad_pkg.sv */
package mpad_pkg;
  // Wishbone register offsets (byte addresses, one word each).
  localparam logic [7:0] REG_RNR = 8'h00;
  localparam logic [7:0] REG_RBAR = 8'h04;
  localparam logic [7:0] REG_RLAR = 8'h08;
  localparam logic [7:0] REG_ATTR_LO = 8'h0C;
  localparam logic [7:0] REG_ATTR_HI = 8'h10;
  localparam logic [7:0] REG_FAULT_STAT = 8'h14;
  localparam logic [7:0] REG_FAULT_ADDR = 8'h18;
  // Geometry.
  localparam int NUM_REGIONS = 8;
  localparam int REGION_IDX_W = 3;
  localparam int GRANULE_W = 5;
  localparam logic [4:0] LIMIT_FILL = 5'h1F;
  localparam logic [4:0] BASE_FILL = 5'h00;
  // Region register field positions.
  localparam int RB_SH_HI = 4;
  localparam int RB_SH_LO = 3;
  localparam int RB_AP_HI = 2;
  localparam int RB_AP_LO = 1;
  localparam int RB_XN = 0;
  localparam int RL_IDX_HI = 3;
  localparam int RL_IDX_LO = 1;
  localparam int RL_EN = 0;
  localparam logic [31:0] RBAR_MASK = 32'hFFFF_FFFF;
  localparam logic [31:0] RLAR_MASK = 32'hFFFF_FFEF;
  localparam logic [31:0] RNR_MASK = 32'h0000_00FF;
  // Attribute nibble encodings.
  localparam logic [3:0] NIB_DEVICE = 4'h0;
  localparam logic [3:0] NIB_NONCACHE = 4'h4;
  localparam logic [1:0] POL_WT_TRANS = 2'h0;
  localparam logic [1:0] POL_WB_TRANS = 2'h1;
  localparam logic [1:0] POL_WT_NONTRANS = 2'h2;
  localparam logic [1:0] POL_WB_NONTRANS = 2'h3;
  // Access permission encodings.
  localparam logic [1:0] AP_RW_PRIV = 2'h0;
  localparam logic [1:0] AP_RW_ANY = 2'h1;
  localparam logic [1:0] AP_RO_PRIV = 2'h2;
  localparam logic [1:0] AP_RO_ANY = 2'h3;
  // Shareability: outer shareable and inner shareable use the global monitor.
  localparam logic [1:0] SH_OUTER = 2'h2;
  localparam logic [1:0] SH_INNER = 2'h3;
  // Decoded memory class.
  typedef enum logic [1:0] {MPAD_NORMAL_NC, MPAD_NORMAL_WT, MPAD_NORMAL_WB, MPAD_DEVICE} mpad_mem_t;
endpackage

/* rtl/mpad_top.sv */
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// R01 - Upper attribute nibble zero selects device memory with ordering from lower bits.
// R02 - Upper nibble is outer policy; 0100 means outer non-cacheable.
// R03 - Outer top bits: WT transient, WB transient, WT, WB non-transient.
// R04 - Software avoids transient encodings whose allocation bits are both zero.
// R05 - Lower nibble is inner policy; 0000 under normal outer is unpredictable.
// R06 - Inner nibble 0100 means inner non-cacheable.
// R07 - Inner top bits carry the same four policies as outer.
// R08 - R bit is read-allocate, W bit write-allocate; one allocates.
// R09 - A permission violation raises a memory management fault, access not completed.
// R10 - Software writes region number, then base at +4, limit at +8.
// R11 - Software issues a barrier before changes affecting outstanding transfers.
// R12 - Software issues a barrier after changes that later transfers need.
// R13 - Data sync barrier then instruction sync barrier for immediate effect.
// R14 - Software masks interrupts while changing and disables unused regions.
// R15 - Flash advised non-shareable write-through, nibbles 1010.
// R16 - Internal SRAM shareable WT, external SRAM WB allocate 1111, peripherals device.
// R17 - Shareability picks global or only local exclusive monitor.
// R18 - Device byte bits three to two give gathering, reorder, early-ack type.
// R19 - Attribute byte n sits at bits 8n+7:8n of two indirection registers.
// R20 - Limit bound is stored limit bits with 0x1F appended.
// R21 - Base bound is stored base bits with low five bits zero.
// R22 - Decoded attributes accompany each check result in the same cycle.
// R23 - Fault marks exactly the faulting access and alters no region configuration.
module mpad_top (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Access check request from the load/store path.
  input wire logic chk_valid,
  input wire logic [31:0] chk_addr,
  input wire logic chk_write,
  input wire logic chk_priv,
  input wire logic chk_exec,
  // Check result with decoded attributes.
  output logic res_valid,
  output logic res_fault,
  output logic res_hit,
  output logic [1:0] res_mem_type,
  output logic [1:0] res_inner_type,
  output logic [1:0] res_device_order,
  output logic [1:0] res_outer_alloc,
  output logic [1:0] res_inner_alloc,
  output logic res_transient,
  output logic res_global_monitor,
  output logic res_attr_unpredictable,
  // Memory management fault pulse.
  output logic memory_management_fault
);
  localparam int NR = mpad_pkg::NUM_REGIONS;
  // Full-width write mask for registers with no reserved bits.
  localparam logic [31:0] RBAR_ALL = mpad_pkg::RBAR_MASK;

  logic [7:0] region_number_select_r;
  logic [31:0] region_base_r [NR];
  logic [31:0] region_limit_r [NR];
  logic [31:0] attribute_indirection_low_r;
  logic [31:0] attribute_indirection_high_r;
  logic [31:0] fault_addr_r;
  logic fault_seen_r;
  logic [7:0] fault_count_r;
  logic wb_ack_r;
  logic [31:0] wb_dat_r;
  logic res_valid_r, res_fault_r, res_hit_r, res_transient_r, res_gmon_r, res_unp_r, mmf_r;
  logic [1:0] res_type_r, res_itype_r, res_order_r, res_oalloc_r, res_ialloc_r;

  // Byte-lane merge used by every writable register except the fault status, which any write clears.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel, input logic [31:0] mask);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (sel[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
    return r & mask;
  endfunction

  // Bus decode.
  // The standing ack masks the request, so a held cycle is taken only once.
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_r;
  wire bus_wr = bus_req && wb_we_i;
  wire hit_rnr = (wb_adr_i == mpad_pkg::REG_RNR);
  wire hit_rbar = (wb_adr_i == mpad_pkg::REG_RBAR);
  wire hit_rlar = (wb_adr_i == mpad_pkg::REG_RLAR);
  wire hit_alo = (wb_adr_i == mpad_pkg::REG_ATTR_LO);
  wire hit_ahi = (wb_adr_i == mpad_pkg::REG_ATTR_HI);
  wire hit_fst = (wb_adr_i == mpad_pkg::REG_FAULT_STAT);
  wire hit_fad = (wb_adr_i == mpad_pkg::REG_FAULT_ADDR);
  wire [2:0] sel_region = region_number_select_r[mpad_pkg::REGION_IDX_W-1:0];
  wire region_impl = (region_number_select_r < 8'(NR));

  // Read mux; unmapped and unimplemented regions read zero.
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    if (hit_rnr)
      rd_mux = {24'h0, region_number_select_r};
    else if (hit_rbar && region_impl)
      rd_mux = region_base_r[sel_region];
    else if (hit_rlar && region_impl)
      rd_mux = region_limit_r[sel_region];
    else if (hit_alo)
      rd_mux = attribute_indirection_low_r;
    else if (hit_ahi)
      rd_mux = attribute_indirection_high_r;
    else if (hit_fst)
      rd_mux = {23'h0, fault_seen_r, fault_count_r};
    else if (hit_fad)
      rd_mux = fault_addr_r;
  end

  // Bus acknowledge and read data, one cycle after the request.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h0;
    end
    else
    begin
      wb_ack_r <= bus_req;
      wb_dat_r <= bus_req ? rd_mux : 32'h0;
    end
  end

  // Global registers written by software; check faults never touch them.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      region_number_select_r <= 8'h00;
      attribute_indirection_low_r <= 32'h0;
      attribute_indirection_high_r <= 32'h0;
    end
    else if (bus_wr)
    begin
      if (hit_rnr) region_number_select_r <= 8'(lane_merge({24'h0, region_number_select_r}, wb_dat_i,
                                                            wb_sel_i, mpad_pkg::RNR_MASK)); // R10
      if (hit_alo) attribute_indirection_low_r <= lane_merge(attribute_indirection_low_r, wb_dat_i,
                                                             wb_sel_i, RBAR_ALL);
      if (hit_ahi) attribute_indirection_high_r <= lane_merge(attribute_indirection_high_r, wb_dat_i,
                                                              wb_sel_i, RBAR_ALL);
    end
  end

  // Per-region match and permission logic, one slice per region.
  logic [NR-1:0] reg_match;
  logic [NR-1:0] reg_deny;
  genvar g;
  generate
    for (g = 0; g < NR; g++)
    begin : g_region
      wire [31:0] lo_bound = {region_base_r[g][31:mpad_pkg::GRANULE_W], mpad_pkg::BASE_FILL}; // R21
      wire [31:0] hi_bound = {region_limit_r[g][31:mpad_pkg::GRANULE_W], mpad_pkg::LIMIT_FILL}; // R20
      wire [1:0] ap = region_base_r[g][mpad_pkg::RB_AP_HI:mpad_pkg::RB_AP_LO];
      wire ro = (ap == mpad_pkg::AP_RO_PRIV) || (ap == mpad_pkg::AP_RO_ANY);
      wire priv_only = (ap == mpad_pkg::AP_RW_PRIV) || (ap == mpad_pkg::AP_RO_PRIV);
      assign reg_match[g] = region_limit_r[g][mpad_pkg::RL_EN] && chk_addr >= lo_bound && chk_addr <= hi_bound;
      assign reg_deny[g] = (priv_only && !chk_priv) || (ro && chk_write)
        || (chk_exec && region_base_r[g][mpad_pkg::RB_XN]);

      // Region storage reached through the region number select.
      always_ff @(posedge clk_sys)
      begin
        if (!nrst)
        begin
          region_base_r[g] <= 32'h0;
          region_limit_r[g] <= 32'h0;
        end
        else if (bus_wr && region_impl && sel_region == 3'(g))
        begin
          if (hit_rbar) region_base_r[g] <= lane_merge(region_base_r[g], wb_dat_i, wb_sel_i, RBAR_ALL);
          if (hit_rlar) region_limit_r[g] <= lane_merge(region_limit_r[g], wb_dat_i, wb_sel_i,
                                                        mpad_pkg::RLAR_MASK);
        end
      end
    end
  endgenerate

  // Lowest-numbered matching region wins; multiple hits are resolved by priority.
  logic [2:0] win_idx;
  always_comb
  begin
    win_idx = 3'h0;
    for (int i = NR - 1; i >= 0; i--)
      if (reg_match[i]) win_idx = 3'(i);
  end
  wire any_hit = |reg_match;
  wire [2:0] attr_idx = region_limit_r[win_idx][mpad_pkg::RL_IDX_HI:mpad_pkg::RL_IDX_LO];
  wire [63:0] attr_all = {attribute_indirection_high_r, attribute_indirection_low_r};
  wire [7:0] memory_attribute_byte = attr_all[{attr_idx, 3'h0} +: 8]; // R19
  wire [1:0] win_sh = region_base_r[win_idx][mpad_pkg::RB_SH_HI:mpad_pkg::RB_SH_LO];

  // No background region: a miss or a denied hit both fault.
  wire chk_fault = chk_valid && (!any_hit || reg_deny[win_idx]); // R09
  // Faults feed only the result and capture registers; region storage never sees them.

  // Attribute decode of the byte that the winning region selects.
  logic is_dev;
  logic [1:0] dev_order, o_alloc, i_alloc;
  mpad_pkg::mpad_mem_t o_type, i_type;
  logic o_trans, i_trans, attr_unp;
  mpad_attr_decode u_dec (
    .attr_byte(memory_attribute_byte),
    .is_device(is_dev),
    .device_order(dev_order),
    .outer_type(o_type),
    .inner_type(i_type),
    .outer_transient(o_trans),
    .inner_transient(i_trans),
    .outer_alloc(o_alloc),
    .inner_alloc(i_alloc),
    .attr_unpredictable(attr_unp)
  );

  // Device memory is always shared; normal memory follows the region field.
  wire gmon = is_dev || win_sh == mpad_pkg::SH_OUTER || win_sh == mpad_pkg::SH_INNER; // R17

  // Registered check result, one cycle after the request.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      res_valid_r <= 1'b0;
      res_fault_r <= 1'b0;
      res_hit_r <= 1'b0;
      res_type_r <= 2'h0;
      res_itype_r <= 2'h0;
      res_order_r <= 2'h0;
      res_oalloc_r <= 2'h0;
      res_ialloc_r <= 2'h0;
      res_transient_r <= 1'b0;
      res_gmon_r <= 1'b0;
      res_unp_r <= 1'b0;
      mmf_r <= 1'b0;
    end
    else
    begin
      res_valid_r <= chk_valid;
      res_fault_r <= chk_fault; // R09
      mmf_r <= chk_fault; // R23
      res_hit_r <= chk_valid && any_hit;
      res_type_r <= o_type; // R22
      res_itype_r <= i_type; // R22
      res_order_r <= is_dev ? dev_order : 2'h0; // R18
      res_oalloc_r <= o_alloc;
      res_ialloc_r <= i_alloc;
      res_transient_r <= o_trans || i_trans;
      res_gmon_r <= gmon; // R17
      res_unp_r <= attr_unp;
    end
  end

  // Fault capture for software; set wins over the clearing write.
  wire clr_fault = bus_wr && hit_fst;
  // The count wraps to zero on the 256th fault; any write to the status register clears it.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      fault_seen_r <= 1'b0;
      fault_count_r <= 8'h00;
      fault_addr_r <= 32'h0;
    end
    else
    begin
      fault_seen_r <= chk_fault ? 1'b1 : (clr_fault ? 1'b0 : fault_seen_r);
      fault_count_r <= chk_fault ? fault_count_r + 8'h01 : (clr_fault ? 8'h00 : fault_count_r);
      if (chk_fault) fault_addr_r <= chk_addr;
    end
  end

  // Outputs straight from flip-flops.
  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;
  assign res_valid = res_valid_r;
  assign res_fault = res_fault_r;
  assign res_hit = res_hit_r;
  assign res_mem_type = res_type_r;
  assign res_inner_type = res_itype_r;
  assign res_device_order = res_order_r;
  assign res_outer_alloc = res_oalloc_r;
  assign res_inner_alloc = res_ialloc_r;
  assign res_transient = res_transient_r;
  assign res_global_monitor = res_gmon_r;
  assign res_attr_unpredictable = res_unp_r;
  assign memory_management_fault = mmf_r;
endmodule // mpad_top
`default_nettype wire

/* verification/mpad_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module mpad_checker (
  // Clock, reset and register bus.
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Check path and result.
  input wire logic chk_valid,
  input wire logic res_valid,
  input wire logic res_fault,
  input wire logic res_hit,
  input wire logic [1:0] res_mem_type,
  input wire logic [1:0] res_device_order,
  input wire logic [1:0] res_outer_alloc,
  input wire logic res_global_monitor,
  input wire logic memory_management_fault
);
  // Every check runs on the core clock and rests while reset is low.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Bus answer timing, result timing and result contents.
  AST_WB_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack not next cycle");
  AST_WB_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_WB_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  AST_RES_LATENCY: assert property (chk_valid |=> res_valid) else $error("result missing");
  AST_RES_NO_SPUR: assert property (!chk_valid |=> !res_valid) else $error("result without access");
  AST_FAULT_PULSE: assert property (
    memory_management_fault == (res_valid && res_fault)) else $error("fault pulse");
  AST_MISS_FAULT: assert property (res_valid && !res_hit |-> res_fault) else $error("miss without fault");
  AST_DEV_ORDER: assert property (
    res_valid && res_mem_type != 2'h3 |-> res_device_order == 2'h0) else $error("order");
  AST_NC_NOALLOC: assert property (
    res_valid && res_mem_type inside {2'h0, 2'h3} |-> res_outer_alloc == 2'h0) else $error("alloc");
  AST_DEV_GLOBAL: assert property (
    res_valid && res_hit && res_mem_type == 2'h3 |-> res_global_monitor) else $error("monitor");
endmodule // mpad_checker

bind mpad_top mpad_checker u_mpad_checker (.clk_sys, .nrst, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .chk_valid, .res_valid, .res_fault, .res_hit, .res_mem_type, .res_device_order, .res_outer_alloc,
  .res_global_monitor, .memory_management_fault);
`default_nettype wire

/* verification/mpad_lsu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mpad_lsu_model (
  // Clock, reset and bench request.
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic req_go,
  input wire logic [31:0] req_addr,
  input wire logic req_write,
  input wire logic req_priv,
  input wire logic req_exec,
  // Access presented for checking.
  output logic chk_valid,
  output logic [31:0] chk_addr,
  output logic [2:0] chk_kind
);
  // One access per requested cycle; idle qualifiers toggle so stale values never pass for a request.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      chk_valid <= 1'b0;
      chk_addr <= 32'h0;
      chk_kind <= 3'h0;
    end
    else
    begin
      chk_valid <= req_go;
      chk_addr <= req_go ? req_addr : ~chk_addr;
      chk_kind <= req_go ? {req_write, req_priv, req_exec} : ~chk_kind;
    end
  end
endmodule // mpad_lsu_model
`default_nettype wire

/* verification/mpu_attribute_decode_and_fault_test.sv */
`timescale 1ns/1ps
`default_nettype none
module mpu_attribute_decode_and_fault_test;
  typedef struct packed {logic f; logic h; logic [1:0] mt; logic [1:0] it; logic [1:0] od; logic [1:0] oa;
    logic [1:0] ia; logic tr; logic gl; logic un; logic [1:0] lv;} mpad_exp_t;
  // Bench state and design signals.
  logic clk_sys = 1'b0, nrst = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic req_go = 1'b0, req_write = 1'b0, req_priv = 1'b0, req_exec = 1'b0, fw, h0, h1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, req_addr = 32'h0, wb_dat_o, chk_addr, rd, last_flt, ra;
  logic [2:0] chk_kind;
  logic wb_ack_o, chk_valid, res_valid, res_fault, res_hit, res_transient, res_global_monitor;
  logic res_attr_unpredictable, memory_management_fault;
  logic [1:0] res_mem_type, res_inner_type, res_device_order, res_outer_alloc, res_inner_alloc;
  logic [7:0] tbl [8] = '{8'h04, 8'h0C, 8'h44, 8'hAA, 8'hFF, 8'h36, 8'h50, 8'h9B};
  int failures = 0, n_checks = 0, cyc_n = 0, nflt = 0;
  mpad_exp_t expq [$];
  mpad_exp_t me;
  // Block under test and the load/store path model.
  mpad_top u_mpad_top (.clk_sys, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .chk_valid, .chk_addr, .chk_write(chk_kind[2]), .chk_priv(chk_kind[1]),
    .chk_exec(chk_kind[0]), .res_valid, .res_fault, .res_hit, .res_mem_type, .res_inner_type, .res_device_order,
    .res_outer_alloc, .res_inner_alloc, .res_transient, .res_global_monitor, .res_attr_unpredictable,
    .memory_management_fault);
  mpad_lsu_model u_mpad_lsu_model (.clk_sys, .nrst, .req_go, .req_addr, .req_write, .req_priv, .req_exec,
    .chk_valid, .chk_addr, .chk_kind);
  // Nibble helpers for expected attributes.
  function automatic logic [1:0] nty(input logic [3:0] n); return (n == 4'h4) ? 2'h0 : (n[2] ? 2'h2 : 2'h1); endfunction
  function automatic logic [1:0] aloc(input logic [3:0] n); return (n == 4'h4) ? 2'h0 : n[1:0]; endfunction
  function automatic logic trn(input logic [3:0] n); return !n[3] && n != 4'h4; endfunction
  function automatic mpad_exp_t ex(input logic [7:0] a, input logic [1:0] sh, input logic f, input logic h);
    mpad_exp_t e;
    e = '0;
    e.f = f;
    e.h = h;
    if (f || !h) return e;
    if (a[7:4] == 4'h0) return '{1'b0, 1'b1, 2'h3, 2'h3, a[3:2], 2'h0, 2'h0, 1'b0, 1'b1, 1'b0, 2'h3};
    e.mt = nty(a[7:4]);
    e.it = nty(a[3:0]);
    e.oa = aloc(a[7:4]);
    e.ia = aloc(a[3:0]);
    e.tr = trn(a[7:4]) | trn(a[3:0]);
    e.gl = sh[1];
    e.un = (a[3:0] == 4'h0) | (trn(a[7:4]) & a[5:4] == 2'h0) | (trn(a[3:0]) & a[1:0] == 2'h0);
    e.lv = (a[3:0] == 4'h0) ? 2'h2 : 2'h3;
    return e;
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (e !== s)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Classic single Wishbone cycle, held until ack is sampled.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] sel = 4'hF);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    cmp("register read", e, rd);
  endtask
  task automatic setreg(input logic [31:0] n, input logic [31:0] b, input logic [31:0] l);
    wb(1'b1, 8'h00, n);
    wb(1'b1, 8'h04, b);
    wb(1'b1, 8'h08, l);
  endtask
  // One access per call, noting its expected result.
  task automatic acc(input logic [31:0] a, input logic w, input logic p, input logic x, input mpad_exp_t e);
    @(posedge clk_sys);
    req_go <= 1'b1;
    req_addr <= a;
    req_write <= w;
    req_priv <= p;
    req_exec <= x;
    expq.push_back(e);
    nflt += e.f;
    if (e.f) last_flt = a;
  endtask
  task automatic idle;
    @(posedge clk_sys);
    req_go <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  // Clock generator.
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end
  // Cycle ceiling against hangs.
  always @(posedge clk_sys)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      cmp("timeout", 32'h0, 32'h1);
      wrap_up;
    end
  end
  // Takes the oldest expectation whenever a result appears.
  always @(posedge clk_sys)
  begin
    if (nrst && res_valid === 1'b1)
    begin
      me = expq.pop_front();
      cmp("fault", me.f, res_fault);
      cmp("mm fault", me.f, memory_management_fault);
      cmp("hit", me.h, res_hit);
      if (me.lv != 2'h0) cmp("mem type", me.mt, res_mem_type);
      if (me.lv != 2'h0) cmp("order", me.od, res_device_order);
      if (me.lv != 2'h0) cmp("outer alloc", me.oa, res_outer_alloc);
      if (me.lv != 2'h0) cmp("global", me.gl, res_global_monitor);
      if (me.lv > 2'h1) cmp("transient", me.tr, res_transient);
      if (me.lv > 2'h1) cmp("unpredictable", me.un, res_attr_unpredictable);
      if (me.lv == 2'h3) cmp("inner type", me.it, res_inner_type);
      if (me.lv == 2'h3) cmp("inner alloc", me.ia, res_inner_alloc);
    end
  end
  // Main sequence.
  initial
  begin
    void'($urandom(32'h6d48d78d));
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int k = 0; k < 7; k++) rdc(8'(k * 4), 32'h0);
    $display("test reset done");
    setreg(32'h0, 32'h0000_101A, 32'h0000_1FE1);
    setreg(32'h1, 32'h0000_2002, 32'h0000_200B);
    wb(1'b1, 8'h10, {8'($urandom), 8'($urandom), 8'hAA, 8'($urandom)});
    for (int k = 0; k < 8; k++)
    begin
      wb(1'b1, 8'h0C, {24'h0, tbl[k]});
      acc(32'h0000_1000 + 32'(k * 4), 1'b0, 1'b0, 1'b0, ex(tbl[k], 2'h3, 1'b0, 1'b1));
      idle;
    end
    acc(32'h0000_201F, 1'b0, 1'b1, 1'b0, ex(8'hAA, 2'h0, 1'b0, 1'b1));
    acc(32'h0000_0FFF, 1'b0, 1'b1, 1'b0, ex(8'h00, 2'h0, 1'b1, 1'b0));
    acc(32'h0000_1FFF, 1'b0, 1'b1, 1'b0, ex(8'h9B, 2'h3, 1'b0, 1'b1));
    acc(32'h0000_2020, 1'b0, 1'b1, 1'b0, ex(8'h00, 2'h0, 1'b1, 1'b0));
    idle;
    $display("test attributes done");
    for (int ap = 0; ap < 4; ap++)
    begin
      setreg(32'h0, 32'h0000_1018 | 32'(ap * 2), 32'h0000_1FE1);
      for (int pw = 0; pw < 4; pw++) acc(32'h0000_1040, pw[1], pw[0], 1'b0,
        ex(8'h9B, 2'h3, (ap[1] & pw[1]) | (!ap[0] & !pw[0]), 1'b1));
      idle;
    end
    setreg(32'h0, 32'h0000_101B, 32'h0000_1FE1);
    acc(32'h0000_1100, 1'b0, 1'b0, 1'b1, ex(8'h9B, 2'h3, 1'b1, 1'b1));
    acc(32'h0000_1100, 1'b0, 1'b0, 1'b0, ex(8'h9B, 2'h3, 1'b0, 1'b1));
    idle;
    rdc(8'h04, 32'h0000_101B);
    rdc(8'h14, {23'h0, 1'b1, 8'(nflt)});
    rdc(8'h18, last_flt);
    wb(1'b1, 8'h14, 32'h0);
    rdc(8'h14, 32'h0);
    $display("test permissions done");
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    rdc(8'h40, 32'h0);
    setreg(32'h7, 32'h0, 32'hFFFF_FFFE);
    rdc(8'h08, 32'hFFFF_FFEE);
    wb(1'b1, 8'h00, 32'hFFFF_FFFF);
    rdc(8'h00, 32'h0000_00FF);
    rdc(8'h04, 32'h0);
    wb(1'b1, 8'h0C, 32'h0);
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF, 4'h1);
    rdc(8'h0C, 32'h0000_00FF);
    wb(1'b1, 8'h0C, 32'h0000_009B);
    setreg(32'h1, 32'h0000_2006, 32'h0000_200B);
    $display("test registers done");
    for (int k = 0; k < 300; k++)
    begin
      ra = (($urandom % 2) == 0) ? 32'h0000_0FC0 + ($urandom % 32'h80) : 32'h0000_1FC0 + ($urandom % 32'h80);
      fw = 1'($urandom % 2);
      h0 = ra inside {[32'h1000:32'h1FFF]};
      h1 = ra inside {[32'h2000:32'h201F]};
      acc(ra, fw, 1'($urandom % 2), 1'b0,
        ex(h0 ? 8'h9B : 8'hAA, h0 ? 2'h3 : 2'h0, !(h0 | h1) | (h1 & fw), h0 | h1));
    end
    idle;
    cmp("pending results", 32'h0, 32'(expq.size()));
    $display("test random done");
    wrap_up;
  end
endmodule // mpu_attribute_decode_and_fault_test
`default_nettype wire
